// ===== hw/fmac_pkg.sv
// Package: register map, field positions and carrier types of the mask/ADC bank
package fmac_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] FMAC_OFS_MASK_A   = 8'h2C;
	localparam logic [7:0] FMAC_OFS_MASK_B   = 8'h2D;
	localparam logic [7:0] FMAC_OFS_CONV_CTL = 8'h2E;

	localparam logic [7:0] FMAC_RST_MASK_A   = 8'h00;
	localparam logic [7:0] FMAC_RST_MASK_B   = 8'h00;
	localparam logic [7:0] FMAC_RST_CONV_CTL = 8'h30;

	// Writable bits of mask B; bits 1-0 are read-only zero
	localparam logic [7:0] FMAC_WMASK_B      = 8'hFC;
	localparam logic [7:0] FMAC_ALL_ONES     = 8'hFF;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int FMAC_A_CHG_CUR_REG  = 7;
	localparam int FMAC_A_BUS_OVP      = 6;
	localparam int FMAC_A_BAT_OVP      = 5;
	localparam int FMAC_A_BUS_OCP      = 4;
	localparam int FMAC_A_BAT_OCP      = 3;
	localparam int FMAC_A_CONV_OCP     = 2;
	localparam int FMAC_A_AD2_OVP      = 1;
	localparam int FMAC_A_AD1_OVP      = 0;
	localparam int FMAC_B_SYS_SHORT    = 7;
	localparam int FMAC_B_SYS_OVP      = 6;
	localparam int FMAC_B_RB_OVP       = 5;
	localparam int FMAC_B_RB_UVP       = 4;
	localparam int FMAC_B_TSHUT        = 2;
	localparam int FMAC_C_EN           = 7;
	localparam int FMAC_C_ONESHOT      = 6;
	localparam int FMAC_C_RES_HI       = 5;
	localparam int FMAC_C_RES_LO       = 4;
	localparam int FMAC_C_AVG          = 3;
	localparam int FMAC_C_SEED         = 2;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	// Converter settings presented to the measurement engine
	typedef struct packed {
		logic       enable;
		logic       one_shot;
		logic [1:0] resolution;
		logic       running_average_on;
		logic       average_seed_select;
		logic       avg_on_discharge;
	} fmac_conv_cfg_t;

	// Register access request from the serial port decoder
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fmac_req_t;

	typedef enum logic [1:0] {
		FMAC_IDLE = 2'b01,
		FMAC_RDY  = 2'b10
	} fmac_rd_state_t;

endpackage

// ===== hw/fmac_evt_gate.sv
// Per-event edge capture and mask gating for the interrupt pulse
`timescale 1ns/100ps

module fmac_evt_gate #(
	parameter int N = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [N-1:0] i_evt,
	input  wire logic [N-1:0] i_mask,
	output logic      [N-1:0] o_flag,
	output logic              o_pulse
);

	// ****************************************************************
	// Edge capture and gating
	// ****************************************************************
	logic [N-1:0] evt_prev_reg;
	logic [N-1:0] hit;

	// Event inputs are same-clock detector strobes or levels; edge taken
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			evt_prev_reg <= '0;
		else
			evt_prev_reg <= i_evt;
	end

	generate
		for (genvar g = 0; g < N; g++)
		begin : g_bit
			// A masked event still raises its flag, only the pulse is held
			assign hit[g] = i_evt[g] & ~evt_prev_reg[g] & ~i_mask[g];
		end
	endgenerate

	// Flag holds the latest level so status tracks events regardless of mask
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_flag <= '0;
		else
			o_flag <= i_evt; // [R19]
	end

	// One-cycle pulse on any unmasked rising event
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_pulse <= 1'b0;
		else
			o_pulse <= |hit; // [R19]
	end

endmodule

// ===== hw/fmac_regs.sv
// Fault interrupt masks and converter control registers
//
// Overview of operation
// R1: Mask A bit7 gates charge-current regulation events
// R2: Mask A bit6 gates input bus overvoltage
// R3: Mask A bit5 gates battery overvoltage
// R4: Mask A bit4 gates input overcurrent
// R5: Mask A bit3 gates battery overcurrent
// R6: Mask A bit2 gates converter overcurrent
// R7: Mask A bits1,0 gate adapter2, adapter1 overvoltage
// R8: Mask B bit7 gates system short
// R9: Mask B bit6 gates system overvoltage
// R10: Mask B bit5 gates reverse-boost overvoltage
// R11: Mask B bit4 gates reverse-boost undervoltage
// R12: Mask B bit2 thermal shutdown; bits1-0 read-only
// R13: Control bit7 converter enable, watchdog clears
// R14: Control bit6 continuous or one-shot
// R15: Control bits5-4 resolution, reset code 3
// R16: Control bit3 averaging, never on discharge
// R17: Control bit2 average seed source
// R18: Conversion-done interrupt only in one-shot mode
// R19: Unmasked events pulse interrupt; flags always update
// R20: Register-reset command restores power-on values
`timescale 1ns/100ps

module fmac_regs (
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_n,
	input  wire fmac_pkg::fmac_req_t     i_req,
	output logic                         o_ack,
	output logic [7:0]                   o_rdata,
	input  wire logic                    i_reg_rst,
	input  wire logic                    i_wdog_expire,
	input  wire logic                    i_chg_cur_reg,
	input  wire logic                    i_bus_ovp,
	input  wire logic                    i_bat_ovp,
	input  wire logic                    i_bus_ocp,
	input  wire logic                    i_bat_ocp,
	input  wire logic                    i_conv_ocp,
	input  wire logic                    i_ad2_ovp,
	input  wire logic                    i_ad1_ovp,
	input  wire logic                    i_sys_short,
	input  wire logic                    i_sys_ovp,
	input  wire logic                    i_rb_ovp,
	input  wire logic                    i_rb_uvp,
	input  wire logic                    i_tshut,
	input  wire logic                    i_conv_done,
	input  wire logic                    i_conv_done_mask,
	output fmac_pkg::fmac_conv_cfg_t     o_conv_cfg,
	output logic [13:0]                  o_evt_flags,
	output logic                         o_int_pulse
);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [7:0] fault_irq_mask_a_reg;
	logic [7:0] fault_irq_mask_b_reg;
	logic [7:0] converter_control_reg;
	logic       wr_a;
	logic       wr_b;
	logic       wr_c;

	assign wr_a = i_req.wr && (i_req.addr == fmac_pkg::FMAC_OFS_MASK_A);
	assign wr_b = i_req.wr && (i_req.addr == fmac_pkg::FMAC_OFS_MASK_B);
	assign wr_c = i_req.wr && (i_req.addr == fmac_pkg::FMAC_OFS_CONV_CTL);

	// Mask A: every bit writable, cleared by register-reset command
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			fault_irq_mask_a_reg <= fmac_pkg::FMAC_RST_MASK_A;
		else if (i_reg_rst)
			fault_irq_mask_a_reg <= fmac_pkg::FMAC_RST_MASK_A; // [R20]
		else if (wr_a)
			fault_irq_mask_a_reg <= i_req.wdata; // [R1] [R7]
	end

	// Mask B: low two bits never store, so they read back as zero
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			fault_irq_mask_b_reg <= fmac_pkg::FMAC_RST_MASK_B;
		else if (i_reg_rst)
			fault_irq_mask_b_reg <= fmac_pkg::FMAC_RST_MASK_B; // [R20]
		else if (wr_b)
			fault_irq_mask_b_reg <= i_req.wdata & fmac_pkg::FMAC_WMASK_B; // [R12]
	end

	// Converter control: enable also drops on watchdog expiry; the
	// expiry wins over a write in the same cycle so the part goes quiet
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			converter_control_reg <= fmac_pkg::FMAC_RST_CONV_CTL;
		else if (i_reg_rst)
			converter_control_reg <= fmac_pkg::FMAC_RST_CONV_CTL; // [R20] [R15]
		else
		begin
			if (wr_c)
				converter_control_reg <= i_req.wdata;
			if (i_wdog_expire)
				converter_control_reg[fmac_pkg::FMAC_C_EN] <= 1'b0; // [R13]
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Read data registered; unmapped offsets answer zero
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else if (i_req.rd)
			unique case (i_req.addr)
				fmac_pkg::FMAC_OFS_MASK_A:   o_rdata <= fault_irq_mask_a_reg;
				fmac_pkg::FMAC_OFS_MASK_B:   o_rdata <= fault_irq_mask_b_reg;
				fmac_pkg::FMAC_OFS_CONV_CTL: o_rdata <= converter_control_reg;
				default:                     o_rdata <= 8'h00;
			endcase
	end

	// Acknowledge one cycle after any access
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_ack <= 1'b0;
		else
			o_ack <= i_req.rd | i_req.wr;
	end

	// ****************************************************************
	// Converter settings
	// ****************************************************************
	// Registered so the engine sees one coherent set per cycle
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_conv_cfg <= '0;
		else
		begin
			o_conv_cfg.enable <=
				converter_control_reg[fmac_pkg::FMAC_C_EN]; // [R13]
			o_conv_cfg.one_shot <=
				converter_control_reg[fmac_pkg::FMAC_C_ONESHOT]; // [R14]
			o_conv_cfg.resolution <=
				converter_control_reg[fmac_pkg::FMAC_C_RES_HI:
				fmac_pkg::FMAC_C_RES_LO]; // [R15]
			o_conv_cfg.running_average_on <=
				converter_control_reg[fmac_pkg::FMAC_C_AVG]; // [R16]
			o_conv_cfg.average_seed_select <=
				converter_control_reg[fmac_pkg::FMAC_C_SEED]; // [R17]
			// Discharge readings are always single-value
			o_conv_cfg.avg_on_discharge <= 1'b0; // [R16]
		end
	end

	// ****************************************************************
	// Event gating
	// ****************************************************************
	logic [13:0] evt;
	logic [13:0] msk;
	logic        done_evt;

	// Conversion-done counts only while the one-shot bit is set, enabled or not
	assign done_evt = i_conv_done &
		converter_control_reg[fmac_pkg::FMAC_C_ONESHOT]; // [R18]

	assign evt = {done_evt, i_tshut, i_rb_uvp, i_rb_ovp, i_sys_ovp,
		i_sys_short, i_ad1_ovp, i_ad2_ovp, i_conv_ocp, i_bat_ocp,
		i_bus_ocp, i_bat_ovp, i_bus_ovp, i_chg_cur_reg};

	// Regulation entry and exit both announce: feed change, not level
	logic chg_prev_reg;
	logic chg_toggle_reg;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			chg_prev_reg   <= 1'b0;
			chg_toggle_reg <= 1'b0;
		end
		else
		begin
			chg_prev_reg   <= i_chg_cur_reg;
			chg_toggle_reg <= i_chg_cur_reg ^ chg_prev_reg; // [R1]
		end
	end

	logic [13:0] evt_in;
	assign evt_in = {evt[13:1], chg_toggle_reg};

	assign msk = {
		i_conv_done_mask, // [R18]
		fault_irq_mask_b_reg[fmac_pkg::FMAC_B_TSHUT],     // [R12]
		fault_irq_mask_b_reg[fmac_pkg::FMAC_B_RB_UVP],    // [R11]
		fault_irq_mask_b_reg[fmac_pkg::FMAC_B_RB_OVP],    // [R10]
		fault_irq_mask_b_reg[fmac_pkg::FMAC_B_SYS_OVP],   // [R9]
		fault_irq_mask_b_reg[fmac_pkg::FMAC_B_SYS_SHORT], // [R8]
		fault_irq_mask_a_reg[fmac_pkg::FMAC_A_AD1_OVP],   // [R7]
		fault_irq_mask_a_reg[fmac_pkg::FMAC_A_AD2_OVP],   // [R7]
		fault_irq_mask_a_reg[fmac_pkg::FMAC_A_CONV_OCP],  // [R6]
		fault_irq_mask_a_reg[fmac_pkg::FMAC_A_BAT_OCP],   // [R5]
		fault_irq_mask_a_reg[fmac_pkg::FMAC_A_BUS_OCP],   // [R4]
		fault_irq_mask_a_reg[fmac_pkg::FMAC_A_BAT_OVP],   // [R3]
		fault_irq_mask_a_reg[fmac_pkg::FMAC_A_BUS_OVP],   // [R2]
		fault_irq_mask_a_reg[fmac_pkg::FMAC_A_CHG_CUR_REG] // [R1]
	};

	fmac_evt_gate #(
		.N (14)
	) u_gate (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_evt   (evt_in),
		.i_mask  (msk),
		.o_flag  (o_evt_flags),
		.o_pulse (o_int_pulse)
	);

endmodule

// ===== dv/fmac_regs_asserts.sv
// Checker: port-level properties of the mask and converter bank
`timescale 1ns/100ps
module fmac_regs_asserts (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire fmac_pkg::fmac_req_t      i_req,
	input  wire logic                     o_ack,
	input  wire logic [7:0]               o_rdata,
	input  wire logic                     i_reg_rst,
	input  wire logic                     i_wdog_expire,
	input  wire logic                     i_bus_ovp,
	input  wire fmac_pkg::fmac_conv_cfg_t o_conv_cfg,
	input  wire logic [13:0]              o_evt_flags,
	input  wire logic                     o_int_pulse
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ********************************
	// Converter control
	// ********************************
	// Config output trails the register by one cycle
	sequence s_wr_ctl;
		i_req.wr && i_req.addr == fmac_pkg::FMAC_OFS_CONV_CTL && !i_reg_rst;
	endsequence
	property p_ctl_fields;
		s_wr_ctl |-> ##2 o_conv_cfg[5:1] == $past(i_req.wdata[6:2], 2);
	endproperty
	a_ctl_fields: assert property (p_ctl_fields)
		else $error("control fields not taken from write");
	property p_ctl_en;
		s_wr_ctl ##0 !i_wdog_expire |-> ##2
			o_conv_cfg.enable == $past(i_req.wdata[7], 2);
	endproperty
	a_ctl_en: assert property (p_ctl_en)
		else $error("enable not taken from write");
	property p_wdog;
		i_wdog_expire |-> ##2 !o_conv_cfg.enable;
	endproperty
	a_wdog: assert property (p_wdog)
		else $error("enable survived watchdog");
	property p_regrst;
		i_reg_rst |-> ##2 o_conv_cfg == 7'h18;
	endproperty
	a_regrst: assert property (p_regrst)
		else $error("control not restored by register reset");
	property p_no_disch;
		!o_conv_cfg.avg_on_discharge;
	endproperty
	a_no_disch: assert property (p_no_disch)
		else $error("averaging offered on discharge");
	// ********************************
	// Masks and events
	// ********************************
	sequence s_rd_b;
		i_req.rd && i_req.addr == fmac_pkg::FMAC_OFS_MASK_B;
	endsequence
	property p_rd_b;
		s_rd_b |=> o_ack && o_rdata[1:0] == 2'h0;
	endproperty
	a_rd_b: assert property (p_rd_b)
		else $error("reserved mask bits read nonzero");
	property p_flag;
		i_bus_ovp |=> o_evt_flags[1];
	endproperty
	a_flag: assert property (p_flag)
		else $error("event flag missed");
	// A pulse with no flag movement means a spurious interrupt
	property p_pulse_cause;
		o_int_pulse |-> o_evt_flags != $past(o_evt_flags)
			|| $past(o_evt_flags) != $past(o_evt_flags, 2);
	endproperty
	a_pulse_cause: assert property (p_pulse_cause)
		else $error("interrupt pulse without event");
endmodule

// ===== dv/fmac_host.sv
// Host model: single-byte register reads and writes
`timescale 1ns/100ps
module fmac_host (
	input  wire logic           i_clk,
	input  wire logic           i_ack,
	input  wire logic [7:0]     i_rdata,
	output fmac_pkg::fmac_req_t o_req
);
	initial o_req = '0;
	// One request cycle; idle bus carries inverted junk, never stale data
	task automatic xfer(input logic w, input logic [7:0] a, d,
		output logic [7:0] q, output logic k);
		@(posedge i_clk) #1 o_req = '{w, !w, a, d};
		@(posedge i_clk) #1 o_req = '{1'b0, 1'b0, ~a, ~d};
		k = i_ack;
		q = i_rdata;
	endtask
endmodule

// ===== dv/testbench.sv
// Testbench: self-checking run of the mask and converter bank
`timescale 1ns/100ps
module testbench;
	logic                     i_clk = 0;
	logic                     i_rst_n = 0;
	logic                     reg_rst = 0;
	logic                     wdog = 0;
	logic                     cdone = 0;
	logic                     cmask = 0;
	logic [12:0]              ev = '0;
	logic                     ack, k, pulse;
	logic [7:0]               rdata, q;
	logic [13:0]              flags;
	fmac_pkg::fmac_req_t      req;
	fmac_pkg::fmac_conv_cfg_t cfg;
	int                       fail_count = 0;
	int                       num_checks = 0;
	always #2.5 i_clk = ~i_clk;
	fmac_host u_fmac_host (.i_clk(i_clk), .i_ack(ack), .i_rdata(rdata),
		.o_req(req));
	fmac_regs u_fmac_regs (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .o_ack(ack),
		.o_rdata(rdata), .i_reg_rst(reg_rst), .i_wdog_expire(wdog),
		.i_chg_cur_reg(ev[0]), .i_bus_ovp(ev[1]), .i_bat_ovp(ev[2]),
		.i_bus_ocp(ev[3]), .i_bat_ocp(ev[4]), .i_conv_ocp(ev[5]),
		.i_ad2_ovp(ev[6]), .i_ad1_ovp(ev[7]), .i_sys_short(ev[8]),
		.i_sys_ovp(ev[9]), .i_rb_ovp(ev[10]), .i_rb_uvp(ev[11]),
		.i_tshut(ev[12]), .i_conv_done(cdone), .i_conv_done_mask(cmask),
		.o_conv_cfg(cfg), .o_evt_flags(flags), .o_int_pulse(pulse));
	// ********************************
	// Shared tasks
	// ********************************
	task automatic check(input string n, input logic [13:0] s, e);
		num_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, d);
		u_fmac_host.xfer(1'b1, a, d, q, k);
		check("ack", k, 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, e);
		u_fmac_host.xfer(1'b0, a, 8'h00, q, k);
		check("ack", k, 1'b1);
		check("rdata", q, e);
	endtask
	// Raise one event for a cycle; window spans the falling change too
	task automatic hit(input int b, output logic p, f);
		p = 0;
		f = 0;
		@(posedge i_clk) #1 {cdone, ev} = 14'h0001 << b;
		repeat (4)
		begin
			@(posedge i_clk) #1 {cdone, ev} = '0;
			p |= pulse;
			f |= flags[b];
		end
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task automatic t_defaults;
		rd(8'h2C, 8'h00);
		rd(8'h2D, 8'h00);
		rd(8'h2E, 8'h30);
		rd(8'h2F, 8'h00);
		check("cfg", cfg, 7'h18);
	endtask
	task automatic t_access;
		wr(8'h2C, 8'hFF);
		wr(8'h2D, 8'hFF);
		wr(8'h2E, 8'hFF);
		wr(8'h2F, 8'hFF);
		rd(8'h2C, 8'hFF);
		rd(8'h2D, 8'hFC);
		rd(8'h2F, 8'h00);
		check("cfg", cfg, 7'h7E);
		@(posedge i_clk) #1 reg_rst = 1;
		@(posedge i_clk) #1 reg_rst = 0;
		t_defaults();
	endtask
	task automatic t_wdog;
		wr(8'h2E, 8'hFF);
		@(posedge i_clk) #1 wdog = 1;
		@(posedge i_clk) #1 wdog = 0;
		rd(8'h2E, 8'h7F);
		check("cfg", cfg, 7'h3E);
		// Expiry in the very cycle of a write: other bits land, enable stays off
		fork
			wr(8'h2E, 8'hF0);
			begin
				@(posedge i_clk) #1 wdog = 1;
				@(posedge i_clk) #1 wdog = 0;
			end
		join
		rd(8'h2E, 8'h70);
	endtask
	// Every resolution code; done event only counts in one-shot mode
	task automatic t_ctl;
		logic [7:0] d;
		logic       p, f;
		for (int r = 0; r < 4; r++)
		begin
			d = {r[0], ~r[0], r[1:0], r[1], r[0], 2'b01};
			wr(8'h2E, d);
			// Settings trail the register by one more cycle
			@(posedge i_clk) #1;
			check("cfg", cfg, {d[7:2], 1'b0});
			rd(8'h2E, d);
			hit(13, p, f);
			check("done", p, d[6]);
			// Done mask set: flag still follows, pulse is held back
			@(posedge i_clk) #1 cmask = 1;
			hit(13, p, f);
			check("done_masked", {p, f}, {1'b0, d[6]});
			cmask = 0;
		end
	endtask
	// Own mask bit alone blocks; all other bits set still lets it through
	task automatic t_masks;
		logic [7:0] a, m;
		logic       p, f;
		for (int b = 0; b < 13; b++)
		begin
			a = (b < 8) ? 8'h2C : 8'h2D;
			m = 8'h01 << ((b < 8) ? 7 - b : (b < 12) ? 15 - b : 2);
			wr(a, m);
			wr(a ^ 8'h01, 8'h00);
			hit(b, p, f);
			check("masked", {p, f}, 2'b01);
			wr(a, ~m);
			wr(a ^ 8'h01, 8'hFF);
			hit(b, p, f);
			check("open", {p, f}, 2'b11);
		end
	endtask
	initial
	begin
		repeat (3) @(posedge i_clk);
		#1 i_rst_n = 1;
		t_defaults();
		t_access();
		t_wdog();
		t_ctl();
		t_masks();
		complete_run();
	end
	// Watchdog well beyond the roughly 350 cycles the run needs
	initial
	begin
		#20000;
		fail_count++;
		complete_run();
	end
endmodule
bind fmac_regs fmac_regs_asserts u_fmac_regs_asserts (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .o_ack(o_ack),
	.o_rdata(o_rdata), .i_reg_rst(i_reg_rst),
	.i_wdog_expire(i_wdog_expire), .i_bus_ovp(i_bus_ovp),
	.o_conv_cfg(o_conv_cfg), .o_evt_flags(o_evt_flags),
	.o_int_pulse(o_int_pulse));
